//--- rtl/smi_params.svh
// Purpose: shared constants for the network initialisation link
// Assumes: 100 MHz reference clock
// Notes: long intervals are also module parameters so benches can shorten them
`ifndef SMI_PARAMS_SVH
`define SMI_PARAMS_SVH
`define SMI_CLK_HZ 100000000
`define SMI_RESET_INTERVAL_S 10
`define SMI_REQUEST_INTERVAL_S 2
`define SMI_RESET_INTERVAL_CYC (`SMI_RESET_INTERVAL_S * `SMI_CLK_HZ)
`define SMI_REQUEST_INTERVAL_CYC (`SMI_REQUEST_INTERVAL_S * `SMI_CLK_HZ)
`define SMI_PORTS 8
`define SMI_ADDR_PRIMARY 1'h0
`define SMI_ADDR_SECONDARY 1'h1
`define SMI_SUB_LINE_LSB 0
`define SMI_SUB_FMT_LSB 3
`define SMI_SUB_SPEED_LSB 8
`define SMI_FMT_W 5
`define SMI_SPEED_W 8
`define SMI_XOFF_CHAR 8'h13
`endif

//--- rtl/smi_pkg.sv
// Purpose: types for the network initialisation link
// Assumes: nothing
// Notes: frame kinds on the composite link
package smi_pkg;
    typedef enum logic [1:0] {
        SMI_FR_NONE = 2'b00,
        SMI_FR_RESET = 2'b01,
        SMI_FR_REQUEST = 2'b10,
        SMI_FR_SET = 2'b11
    } smi_frame_t;
    typedef logic [15:0] smi_sub_t;
endpackage : smi_pkg

//--- rtl/smi_link_if.sv
// Purpose: composite link between the local mux and the remote side
// Assumes: one clock; one frame per valid cycle, taken when valid and ready
// Notes: set frame carries one 16-bit subfield per remote port (unallocated are zero)
`timescale 1ns/1ps
interface smi_link_if;
    import smi_pkg::*;
    // local to remote
    logic dn_valid;
    logic dn_ready;
    smi_frame_t dn_kind;
    logic dn_addr;
    logic [127:0] dn_subs;
    logic [7:0] dn_sub_valid;
    // remote to local
    logic up_valid;
    logic up_ready;
    smi_frame_t up_kind;
    logic up_addr;
    logic [7:0] up_active;
    modport local_end (output dn_valid, dn_kind, dn_addr, dn_subs, dn_sub_valid,
        input dn_ready, input up_valid, up_kind, up_addr, up_active, output up_ready);
    modport remote_end (input dn_valid, dn_kind, dn_addr, dn_subs, dn_sub_valid,
        output dn_ready, output up_valid, up_kind, up_addr, up_active, input up_ready);
endinterface : smi_link_if

//--- rtl/smi_local_mux.sv
// Purpose: local mux end of network initialisation
// Assumes: self_test_ok is a level that rises after power-up test passes
// Notes on behaviour
// - after self test, send resets; watch requests
// - resend reset every 10 s until request
// - remote restarts on reset frame
// - remote requests every two seconds
// - relayed secondary request carries address 1
// - request byte: one active bit per port
// - primary ports first ascending, then secondary
// - overflow: primary all, secondary lowest ports
// - send set frames to both remotes
// - answer every request with set frame
// - 16-bit subfield: speed, format, line
// - remote configures ports from subfields
// - terminal throttles with 023 octal or DTR; no throttling logic here, only SMI_XOFF_CHAR is defined
`timescale 1ns/1ps
`include "smi_params.svh"
module smi_local_mux
    import smi_pkg::*;
#(
    parameter int unsigned RESET_INTERVAL_CYC = `SMI_RESET_INTERVAL_CYC,
    parameter int unsigned LINES = `SMI_PORTS
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic self_test_ok,
    input wire logic [LINES*`SMI_SPEED_W-1:0] line_speed,
    input wire logic [LINES*`SMI_FMT_W-1:0] line_fmt,
    output logic [LINES-1:0] line_enable,
    output logic [LINES-1:0] line_is_secondary,
    output logic [LINES*3-1:0] line_port,
    output logic [7:0] primary_active,
    output logic [7:0] secondary_active,
    output logic link_up,
    smi_link_if.local_end link
);
    logic running;
    logic next_running;
    logic got_request;
    logic next_got_request;
    logic [31:0] tick;
    logic [31:0] next_tick;
    logic [7:0] prim;
    logic [7:0] next_prim;
    logic [7:0] sec;
    logic [7:0] next_sec;
    logic [1:0] pend;
    logic [1:0] next_pend;
    logic dn_valid;
    logic next_dn_valid;
    smi_frame_t dn_kind;
    smi_frame_t next_dn_kind;
    logic dn_addr;
    logic next_dn_addr;
    logic [127:0] dn_subs;
    logic [127:0] next_dn_subs;
    logic [7:0] dn_sub_valid;
    logic [7:0] next_dn_sub_valid;
    // mapping, combinational from the stored bitmaps
    logic [LINES-1:0] map_en;
    logic [LINES-1:0] map_sec;
    logic [LINES*3-1:0] map_port;
    logic [7:0] p_line [0:7];
    logic [7:0] s_line [0:7];
    logic [7:0] p_ok;
    logic [7:0] s_ok;

    always_comb begin
        int n;
        n = 0;
        map_en = '0;
        map_sec = '0;
        map_port = '0;
        p_ok = '0;
        s_ok = '0;
        for (int i = 0; i < 8; i++) begin
            p_line[i] = 8'h00;
            s_line[i] = 8'h00;
        end
        for (int i = 0; i < 8; i++) begin
            if (prim[i] && n < LINES) begin
                map_en[n] = 1'b1;
                map_port[n*3 +: 3] = 3'(i);
                p_line[i] = 8'(n);
                p_ok[i] = 1'b1;
                n = n + 1;
            end
        end
        for (int i = 0; i < 8; i++) begin
            if (sec[i] && n < LINES) begin
                map_en[n] = 1'b1;
                map_sec[n] = 1'b1;
                map_port[n*3 +: 3] = 3'(i);
                s_line[i] = 8'(n);
                s_ok[i] = 1'b1;
                n = n + 1;
            end
        end
    end

    function automatic logic [127:0] build_subs(input logic [7:0] ok, input logic [63:0] ln);
        logic [127:0] r;
        logic [7:0] l;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            l = ln[i*8 +: 8];
            if (ok[i]) begin
                r[i*16 + `SMI_SUB_LINE_LSB +: 3] = l[2:0];
                r[i*16 + `SMI_SUB_FMT_LSB +: `SMI_FMT_W] = line_fmt[l*`SMI_FMT_W +: `SMI_FMT_W];
                r[i*16 + `SMI_SUB_SPEED_LSB +: `SMI_SPEED_W] =
                    line_speed[l*`SMI_SPEED_W +: `SMI_SPEED_W];
            end
        end
        return r;
    endfunction : build_subs

    logic [63:0] p_flat;
    logic [63:0] s_flat;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            p_flat[i*8 +: 8] = p_line[i];
            s_flat[i*8 +: 8] = s_line[i];
        end
    end

    assign link.up_ready = !pend[0] && !pend[1];

    always_comb begin
        next_running = running | self_test_ok;
        next_got_request = got_request;
        next_tick = tick;
        next_prim = prim;
        next_sec = sec;
        next_pend = pend;
        next_dn_valid = dn_valid;
        next_dn_kind = dn_kind;
        next_dn_addr = dn_addr;
        next_dn_subs = dn_subs;
        next_dn_sub_valid = dn_sub_valid;
        if (dn_valid && link.dn_ready) begin
            next_dn_valid = 1'b0;
        end
        if (link.up_valid && link.up_ready && link.up_kind == SMI_FR_REQUEST) begin
            next_got_request = 1'b1;
            if (link.up_addr == `SMI_ADDR_SECONDARY) begin
                next_sec = link.up_active;
            end else begin
                next_prim = link.up_active;
            end
            // every request answers both remotes, since a new map may move either
            next_pend = 2'b11;
        end
        // no reset beside a taken request: it would restart the remote just answered
        if (running && !next_got_request) begin
            if (tick == 32'h0) begin
                if (!dn_valid || link.dn_ready) begin
                    next_dn_valid = 1'b1;
                    next_dn_kind = SMI_FR_RESET;
                    next_dn_addr = `SMI_ADDR_PRIMARY;
                    next_dn_subs = '0;
                    next_dn_sub_valid = '0;
                    next_tick = 32'(RESET_INTERVAL_CYC - 1);
                end
            end else begin
                next_tick = tick - 32'h1;
            end
        end
        if (pend != 2'b00 && (!dn_valid || link.dn_ready)) begin
            next_dn_valid = 1'b1;
            next_dn_kind = SMI_FR_SET;
            if (pend[0]) begin
                next_dn_addr = `SMI_ADDR_PRIMARY;
                next_dn_subs = build_subs(p_ok, p_flat);
                next_dn_sub_valid = p_ok;
                next_pend[0] = 1'b0;
            end else begin
                next_dn_addr = `SMI_ADDR_SECONDARY;
                next_dn_subs = build_subs(s_ok, s_flat);
                next_dn_sub_valid = s_ok;
                next_pend[1] = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            running <= 1'b0;
            got_request <= 1'b0;
            tick <= 32'h0;
            prim <= 8'h00;
            sec <= 8'h00;
            pend <= 2'b00;
            dn_valid <= 1'b0;
            dn_kind <= SMI_FR_NONE;
            dn_addr <= 1'b0;
            dn_subs <= '0;
            dn_sub_valid <= 8'h00;
            line_enable <= '0;
            line_is_secondary <= '0;
            line_port <= '0;
        end else begin
            running <= next_running;
            got_request <= next_got_request;
            tick <= next_tick;
            prim <= next_prim;
            sec <= next_sec;
            pend <= next_pend;
            dn_valid <= next_dn_valid;
            dn_kind <= next_dn_kind;
            dn_addr <= next_dn_addr;
            dn_subs <= next_dn_subs;
            dn_sub_valid <= next_dn_sub_valid;
            line_enable <= map_en;
            line_is_secondary <= map_sec;
            line_port <= map_port;
        end
    end

    assign link.dn_valid = dn_valid;
    assign link.dn_kind = dn_kind;
    assign link.dn_addr = dn_addr;
    assign link.dn_subs = dn_subs;
    assign link.dn_sub_valid = dn_sub_valid;
    assign primary_active = prim;
    assign secondary_active = sec;
    assign link_up = got_request;
endmodule : smi_local_mux

//--- rtl/smi_remote_mux.sv
// Purpose: remote side (primary plus optional relayed secondary) of initialisation
// Assumes: active bitmaps are switch levels
// Notes: a relayed secondary shares this end; it is addressed by address 1
`timescale 1ns/1ps
`include "smi_params.svh"
module smi_remote_mux
    import smi_pkg::*;
#(
    parameter int unsigned REQUEST_INTERVAL_CYC = `SMI_REQUEST_INTERVAL_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic self_test_ok,
    input wire logic secondary_present,
    input wire logic [7:0] primary_switch,
    input wire logic [7:0] secondary_switch,
    output logic [127:0] primary_cfg,
    output logic [7:0] primary_ready,
    output logic [127:0] secondary_cfg,
    output logic [7:0] secondary_ready,
    smi_link_if.remote_end link
);
    logic tested;
    logic next_tested;
    logic [31:0] tick;
    logic [31:0] next_tick;
    logic turn;
    logic next_turn;
    logic up_valid;
    logic next_up_valid;
    logic up_addr;
    logic next_up_addr;
    logic [7:0] up_active;
    logic [7:0] next_up_active;
    logic [127:0] next_primary_cfg;
    logic [7:0] next_primary_ready;
    logic [127:0] next_secondary_cfg;
    logic [7:0] next_secondary_ready;
    logic restart;

    assign link.dn_ready = 1'b1;
    assign restart = link.dn_valid && link.dn_kind == SMI_FR_RESET;

    always_comb begin
        next_tested = tested | self_test_ok;
        next_tick = tick;
        next_turn = turn;
        next_up_valid = up_valid;
        next_up_addr = up_addr;
        next_up_active = up_active;
        next_primary_cfg = primary_cfg;
        next_primary_ready = primary_ready;
        next_secondary_cfg = secondary_cfg;
        next_secondary_ready = secondary_ready;
        if (up_valid && link.up_ready) begin
            next_up_valid = 1'b0;
        end
        if (tested) begin
            if (tick == 32'h0) begin
                if (!up_valid || link.up_ready) begin
                    next_up_valid = 1'b1;
                    next_up_addr = turn ? `SMI_ADDR_SECONDARY : `SMI_ADDR_PRIMARY;
                    next_up_active = turn ? secondary_switch : primary_switch;
                    next_turn = secondary_present ? ~turn : 1'b0;
                    next_tick = (turn || !secondary_present) ?
                        32'(REQUEST_INTERVAL_CYC - 1) : 32'h0;
                end
            end else begin
                next_tick = tick - 32'h1;
            end
        end
        if (link.dn_valid && link.dn_kind == SMI_FR_SET) begin
            if (link.dn_addr == `SMI_ADDR_SECONDARY) begin
                next_secondary_cfg = link.dn_subs;
                next_secondary_ready = link.dn_sub_valid & secondary_switch;
            end else begin
                next_primary_cfg = link.dn_subs;
                next_primary_ready = link.dn_sub_valid & primary_switch;
            end
        end
        if (restart) begin
            // restart behaves as power-up: test already passed, restart requesting
            next_tick = 32'h0;
            next_turn = 1'b0;
            next_up_valid = 1'b0;
            next_primary_ready = 8'h00;
            next_secondary_ready = 8'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            tested <= 1'b0;
            tick <= 32'h0;
            turn <= 1'b0;
            up_valid <= 1'b0;
            up_addr <= 1'b0;
            up_active <= 8'h00;
            primary_cfg <= '0;
            primary_ready <= 8'h00;
            secondary_cfg <= '0;
            secondary_ready <= 8'h00;
        end else begin
            tested <= next_tested;
            tick <= next_tick;
            turn <= next_turn;
            up_valid <= next_up_valid;
            up_addr <= next_up_addr;
            up_active <= next_up_active;
            primary_cfg <= next_primary_cfg;
            primary_ready <= next_primary_ready;
            secondary_cfg <= next_secondary_cfg;
            secondary_ready <= next_secondary_ready;
        end
    end

    assign link.up_valid = up_valid;
    assign link.up_kind = SMI_FR_REQUEST;
    assign link.up_addr = up_addr;
    assign link.up_active = up_active;
endmodule : smi_remote_mux

//--- tb/smi_link_assertions.sv
// Purpose: link checks for network initialisation
// Assumes: dn_ready held high by the remote end
// Notes: bitmaps tracked from taken requests
`timescale 1ns/1ps
module smi_link_assertions
    import smi_pkg::*;
#(
    parameter int unsigned RESET_INTERVAL_CYC = 200
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic dn_valid,
    input wire logic dn_ready,
    input wire smi_frame_t dn_kind,
    input wire logic dn_addr,
    input wire logic [127:0] dn_subs,
    input wire logic [7:0] dn_sub_valid,
    input wire logic up_valid,
    input wire logic up_ready,
    input wire smi_frame_t up_kind,
    input wire logic up_addr,
    input wire logic [7:0] up_active
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic req_seen, rst_seen, take, rst_fr, set_fr, subs_clean;
    logic [31:0] gap;
    logic [7:0] prim_bm, sec_bm;
    assign take = up_valid && up_ready;
    assign rst_fr = dn_valid && dn_kind == SMI_FR_RESET;
    assign set_fr = dn_valid && dn_kind == SMI_FR_SET;
    always_comb begin
        subs_clean = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (!dn_sub_valid[i] && dn_subs[16*i +: 16] != 16'h0000) begin
                subs_clean = 1'b0;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            req_seen <= 1'b0;
            rst_seen <= 1'b0;
            gap <= 32'h0;
            prim_bm <= 8'h00;
            sec_bm <= 8'h00;
        end else begin
            req_seen <= req_seen || take;
            rst_seen <= rst_seen || rst_fr;
            gap <= rst_fr ? 32'h0 : gap + 32'h1;
            if (take && !up_addr) begin
                prim_bm <= up_active;
            end
            if (take && up_addr) begin
                sec_bm <= up_active;
            end
        end
    end
    a_reset_gap: assert property (rst_fr && rst_seen |-> gap == RESET_INTERVAL_CYC - 1)
        else $error("reset frame spacing wrong");
    a_reset_stop: assert property (req_seen |-> !rst_fr)
        else $error("reset frame after request");
    a_set_pair: assert property (take |-> ##2 (set_fr && !dn_addr)
        ##1 (set_fr && dn_addr))
        else $error("request not answered by both set frames");
    a_prim_alloc: assert property (set_fr && !dn_addr |-> dn_sub_valid == prim_bm)
        else $error("primary ports not all allocated");
    a_sec_alloc: assert property (set_fr && dn_addr |->
        (dn_sub_valid & ~sec_bm) == 8'h00 &&
        (dn_sub_valid == sec_bm || $countones(dn_sub_valid) + $countones(prim_bm) == 8))
        else $error("secondary allocation wrong");
    a_first_line: assert property (set_fr && !dn_addr && dn_sub_valid[0] |->
        dn_subs[2:0] == 3'h0)
        else $error("primary port zero not on line zero");
    a_subs_clean: assert property (set_fr |-> subs_clean)
        else $error("unallocated subfield not zero");
    a_up_stand: assert property (up_valid && !up_ready |=>
        up_valid && $stable(up_active))
        else $error("request withdrawn or changed");
    a_ready_busy: assert property (take |=> !up_ready)
        else $error("request taken while answer pending");
    a_req_kind: assert property (up_valid |-> up_kind == SMI_FR_REQUEST)
        else $error("remote sent non request frame");
endmodule : smi_link_assertions

//--- tb/statmux_network_init_test.sv
// Purpose: end-to-end bench for network initialisation
// Assumes: both ends joined by one link interface
// Notes: intervals shortened to keep the run brief
`timescale 1ns/1ps
module statmux_network_init_test;
    import smi_pkg::*;
    localparam int unsigned RST_CYC = 200;
    logic ref_clk, reset_n, lst_ok, rst_ok, sec_present, link_up;
    logic [63:0] line_speed;
    logic [39:0] line_fmt;
    logic [7:0] p_sw, s_sw, line_enable, line_is_secondary, primary_active, secondary_active;
    logic [7:0] primary_ready, secondary_ready;
    logic [23:0] line_port;
    logic [127:0] primary_cfg, secondary_cfg;
    int error_cnt = 0;
    int tests_run = 0;
    smi_link_if link ();
    smi_local_mux #(.RESET_INTERVAL_CYC(RST_CYC)) smi_local_mux_inst (.ref_clk(ref_clk),
        .reset_n(reset_n), .self_test_ok(lst_ok), .line_speed(line_speed), .line_fmt(line_fmt),
        .line_enable(line_enable), .line_is_secondary(line_is_secondary), .line_port(line_port),
        .primary_active(primary_active), .secondary_active(secondary_active),
        .link_up(link_up), .link(link));
    smi_remote_mux #(.REQUEST_INTERVAL_CYC(50)) smi_remote_mux_inst (.ref_clk(ref_clk),
        .reset_n(reset_n), .self_test_ok(rst_ok), .secondary_present(sec_present),
        .primary_switch(p_sw), .secondary_switch(s_sw), .primary_cfg(primary_cfg),
        .primary_ready(primary_ready), .secondary_cfg(secondary_cfg),
        .secondary_ready(secondary_ready), .link(link));
    smi_link_assertions #(.RESET_INTERVAL_CYC(RST_CYC)) smi_link_assertions_inst (
        .ref_clk(ref_clk), .reset_n(reset_n), .dn_valid(link.dn_valid), .dn_ready(link.dn_ready),
        .dn_kind(link.dn_kind), .dn_addr(link.dn_addr), .dn_subs(link.dn_subs),
        .dn_sub_valid(link.dn_sub_valid), .up_valid(link.up_valid), .up_ready(link.up_ready),
        .up_kind(link.up_kind), .up_addr(link.up_addr), .up_active(link.up_active));
    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    // kind 0 waits for link_up, kind 1 for a reset frame
    task automatic wait_for(input int kind, input int lim, output int n);
        n = 0;
        while (!(kind == 0 ? link_up === 1'b1 :
            (link.dn_valid === 1'b1 && link.dn_kind === SMI_FR_RESET))) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > lim) begin
                error_cnt++;
                $display("BAD wait %0d exp done got timeout", kind);
                finish_test();
            end
        end
    endtask : wait_for
    task automatic trial(input logic [7:0] p, input logic [7:0] s, input logic sp);
        logic [255:0] cfg;
        logic [15:0] rdy;
        logic [7:0] en, sec, sx;
        logic [23:0] prt;
        int ln, n, i;
        @(posedge ref_clk);
        reset_n <= 1'b0;
        p_sw <= p;
        s_sw <= s;
        sec_present <= sp;
        line_speed <= {$urandom, $urandom};
        line_fmt <= 40'({$urandom, $urandom});
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        #1;
        sx = sp ? s : 8'h00;
        cfg = '0;
        rdy = '0;
        en = '0;
        sec = '0;
        prt = '0;
        ln = 0;
        // primary ports claim lines first; secondary only gets what is left
        for (int k = 0; k < 16; k++) begin
            i = k % 8;
            if ((k < 8 ? p[i] : sx[i]) && ln < 8) begin
                en[ln] = 1'b1;
                sec[ln] = (k >= 8);
                prt[3*ln +: 3] = i[2:0];
                cfg[128*(k/8) + 16*i +: 16] =
                    {line_speed[8*ln +: 8], line_fmt[5*ln +: 5], ln[2:0]};
                rdy[k] = 1'b1;
                ln++;
            end
        end
        wait_for(0, 400, n);
        repeat (110) @(posedge ref_clk);
        #1;
        chk("line_enable", 128'(en), 128'(line_enable));
        for (int l = 0; l < 8; l++) begin
            if (en[l]) begin
                chk("line_map", 128'({sec[l], prt[3*l +: 3]}),
                    128'({line_is_secondary[l], line_port[3*l +: 3]}));
            end
        end
        chk("primary_active", 128'(p), 128'(primary_active));
        chk("secondary_active", 128'(sx), 128'(secondary_active));
        chk("primary_cfg", cfg[127:0], primary_cfg);
        chk("secondary_cfg", cfg[255:128], secondary_cfg);
        chk("ready", 128'(rdy), 128'({secondary_ready, primary_ready}));
    endtask : trial
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        int n;
        logic [31:0] r;
        reset_n = 1'b0;
        lst_ok = 1'b0;
        rst_ok = 1'b0;
        sec_present = 1'b0;
        p_sw = 8'h00;
        s_sw = 8'h00;
        line_speed = '0;
        line_fmt = '0;
        void'($urandom(32'hF6B1));
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (20) begin
            @(posedge ref_clk);
            #1;
            chk("early_frame", 128'h0, 128'(link.dn_valid));
        end
        @(posedge ref_clk);
        lst_ok <= 1'b1;
        wait_for(1, 10, n);
        @(posedge ref_clk);
        #1;
        wait_for(1, 400, n);
        chk("reset_gap", 128'(RST_CYC), 128'(n + 1));
        @(posedge ref_clk);
        rst_ok <= 1'b1;
        wait_for(0, 400, n);
        trial(8'h79, 8'h3D, 1'b1);
        trial(8'h00, 8'hFF, 1'b1);
        trial(8'hFF, 8'hFF, 1'b1);
        trial(8'hA5, 8'h5A, 1'b0);
        repeat (8) begin
            r = $urandom;
            trial(r[7:0], r[15:8], r[16]);
        end
        finish_test();
    end
endmodule : statmux_network_init_test
